//--- hw/ldb_unit_regs.svh
// Purpose: Register offsets, field positions and reset values of the limit unit
// Assumes: 32-bit classic Wishbone, byte addresses, one aligned word per register
// Notes: Registers are at most 16 bits wide in the low half; upper half reads zero
`ifndef LDB_UNIT_REGS_SVH
`define LDB_UNIT_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define OFS_INPUT 8'h00
`define OFS_PARAM0 8'h04
`define OFS_PARAM1 8'h08
`define OFS_CONTROL 8'h0C
`define OFS_COMMAND 8'h10
`define OFS_OUTPUT 8'h14
`define OFS_FLAGS 8'h18
`define OFS_TARGET 8'h1C
`define OFS_PBAND 8'h20
`define OFS_PERIOD 8'h24
`define OFS_INTERVAL 8'h28
`define OFS_POINTER 8'h2C

// ----------------------------------------
// Fields
// ----------------------------------------
`define CTL_OP_LSB 0
`define CTL_DIR_BIT 2
`define CTL_PTR_BCD_BIT 3
`define CMD_GO_BIT 0
`define FLG_FAULT_BIT 0
`define FLG_CARRY_BIT 1
`define FLG_GT_BIT 2
`define FLG_EQ_BIT 3
`define FLG_LT_BIT 4
`define FLG_NEG_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_WORD 16'h0000
`define RST_PBAND 16'h0001
`define RST_PERIOD 16'h0001

`endif

//--- hw/ldb_pkg.sv
// Purpose: Types shared by the limit, dead-band and bias unit
// Assumes: Nothing beyond the register header
// Notes: The whole unit state is one packed struct
package ldb_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_e;

  typedef enum logic [1:0] {
    OP_LIMIT = 2'b00,
    OP_BAND = 2'b01,
    OP_BIAS = 2'b10,
    OP_CTRL = 2'b11
  } op_e;

  typedef struct packed {
    state_e st;
    logic ack;
    logic [31:0] rdat;
    logic [15:0] in_w;
    logic [15:0] p0;
    logic [15:0] p1;
    logic [15:0] target;
    logic [15:0] pband;
    logic [15:0] period;
    logic [15:0] interval;
    logic [15:0] pointer;
    op_e op;
    logic dir_fwd;
    logic ptr_bcd_en;
    logic [15:0] out_w;
    logic fault;
    logic carry;
    logic gt;
    logic eq;
    logic lt;
    logic neg;
    logic done;
  } state_s;

endpackage

//--- hw/limit_deadband_bias_unit.sv
// Purpose: Signed 16-bit limit clamp, dead-band subtract, bias add and
//          clamped deviation control step with flag reporting, behind Wishbone
// Assumes: Single 20 MHz clock, synchronous active-high reset
// Notes: A write of the go bit is the execution condition; one cycle later
//        the selected operation runs and updates output and flags
//
// Behaviour
// - No execution leaves output and flags untouched; a write of the output register still changes output
// - Operands are signed sixteen-bit two's complement
// - Clamp below lower: output lower, less flag
// - Clamp above upper: output upper, greater flag
// - Clamp inside window: input passes unchanged
// - Band below lower: input minus lower, less
// - Band above upper: input minus upper, greater
// - Band inside window: zero output, equals flag
// - Sums and differences wrap, never saturate
// - Upper below lower limit raises fault
// - Non-BCD pointer in BCD mode raises fault
// - Zero output sets the equals flag
// - Output bit fifteen sets negative flag
// - Out-of-range control parameters raise fault
// - Interval twice sampling period raises fault
// - Carry flag marks an executed control step
// - Control output past limits sets greater/less
// - Forward: output grows as process exceeds target
// - Reverse: output grows as process undercuts target
// - Bias add writes input plus bias
// - Negative takes first bias, positive second
// - Zero input gives zero and equals
//
// Local design decisions: register access over Wishbone and the register offsets.
`timescale 1ns/100ps
`include "ldb_unit_regs.svh"

module limit_deadband_bias_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic [15:0] result_o,
  output logic fault_flag_o,
  output logic carry_flag_o,
  output logic greater_flag_o,
  output logic zero_result_flag_o,
  output logic less_flag_o,
  output logic negative_flag_o,
  output logic done_o
);

  ldb_pkg::state_s r;
  ldb_pkg::state_s n;

  logic req;
  logic wr;
  logic go;
  logic out_wr;
  logic signed [15:0] in_s;
  logic signed [15:0] lo_s;
  logic signed [15:0] hi_s;
  logic lim_bad;
  logic ptr_fault;
  logic [3:0] ptr_dig_ok;
  logic [3:0] pband_dig_ok;
  logic [3:0] period_dig_ok;
  logic [3:0] ival_dig_ok;
  logic [15:0] period_bin;
  logic [15:0] ival_bin;

  // ----------------------------------------
  // Operand view and checks
  // ----------------------------------------
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & ~r.ack;
  assign go = wr & wb_sel_i[0] & (wb_adr_i == `OFS_COMMAND) & wb_dat_i[`CMD_GO_BIT];
  assign out_wr = wr & (wb_adr_i == `OFS_OUTPUT) & (|wb_sel_i[1:0]);
  assign in_s = $signed(r.in_w);
  assign lo_s = $signed(r.p0);
  assign hi_s = $signed(r.p1);
  assign lim_bad = hi_s < lo_s;
  assign ptr_fault = r.ptr_bcd_en & ~(&ptr_dig_ok);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_digit
      assign ptr_dig_ok[g] = r.pointer[4*g+3 -: 4] <= 4'h9;
      assign pband_dig_ok[g] = r.pband[4*g+3 -: 4] <= 4'h9;
      assign period_dig_ok[g] = r.period[4*g+3 -: 4] <= 4'h9;
      assign ival_dig_ok[g] = r.interval[4*g+3 -: 4] <= 4'h9;
    end
  endgenerate

  function automatic logic [15:0] bcd_to_bin(input logic [15:0] v);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 3; i >= 0; i--) begin
      acc = 16'(acc * 16'h000A) + {12'h000, v[4*i+3 -: 4]};
    end
    return acc;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    return {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  assign period_bin = bcd_to_bin(r.period);
  assign ival_bin = bcd_to_bin(r.interval);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic signed [15:0] res;
    logic signed [15:0] dev;
    logic c_gt;
    logic c_lt;
    logic c_eq;
    logic bad;
    res = in_s;
    dev = 16'sh0000;
    c_gt = 1'b0;
    c_lt = 1'b0;
    c_eq = 1'b0;
    bad = 1'b0;
    n = r;
    n.done = 1'b0;
    n.ack = 1'b0;

    // Registered ack: one wait state, ack drops the cycle after it is given
    if (req && !r.ack) begin
      n.ack = 1'b1;
      unique case (wb_adr_i)
        `OFS_INPUT: n.rdat = {16'h0000, r.in_w};
        `OFS_PARAM0: n.rdat = {16'h0000, r.p0};
        `OFS_PARAM1: n.rdat = {16'h0000, r.p1};
        `OFS_CONTROL: n.rdat = {28'h0000000, r.ptr_bcd_en, r.dir_fwd, r.op};
        `OFS_OUTPUT: n.rdat = {16'h0000, r.out_w};
        `OFS_FLAGS: n.rdat = {26'h0000000, r.neg, r.lt, r.eq, r.gt, r.carry, r.fault};
        `OFS_TARGET: n.rdat = {16'h0000, r.target};
        `OFS_PBAND: n.rdat = {16'h0000, r.pband};
        `OFS_PERIOD: n.rdat = {16'h0000, r.period};
        `OFS_INTERVAL: n.rdat = {16'h0000, r.interval};
        `OFS_POINTER: n.rdat = {16'h0000, r.pointer};
        default: n.rdat = 32'h00000000;
      endcase
    end
    if (wr) begin
      unique case (wb_adr_i)
        `OFS_INPUT: n.in_w = merge16(r.in_w, wb_dat_i, wb_sel_i);
        `OFS_PARAM0: n.p0 = merge16(r.p0, wb_dat_i, wb_sel_i);
        `OFS_PARAM1: n.p1 = merge16(r.p1, wb_dat_i, wb_sel_i);
        `OFS_CONTROL: begin
          if (wb_sel_i[0]) begin
            n.op = ldb_pkg::op_e'(wb_dat_i[`CTL_OP_LSB +: 2]);
            n.dir_fwd = wb_dat_i[`CTL_DIR_BIT];
            n.ptr_bcd_en = wb_dat_i[`CTL_PTR_BCD_BIT];
          end
        end
        // Manual write of the output word while nothing executes
        `OFS_OUTPUT: n.out_w = merge16(r.out_w, wb_dat_i, wb_sel_i);
        `OFS_TARGET: n.target = merge16(r.target, wb_dat_i, wb_sel_i);
        `OFS_PBAND: n.pband = merge16(r.pband, wb_dat_i, wb_sel_i);
        `OFS_PERIOD: n.period = merge16(r.period, wb_dat_i, wb_sel_i);
        `OFS_INTERVAL: n.interval = merge16(r.interval, wb_dat_i, wb_sel_i);
        `OFS_POINTER: n.pointer = merge16(r.pointer, wb_dat_i, wb_sel_i);
        default: n.rdat = n.rdat;
      endcase
    end

    unique case (r.st)
      ldb_pkg::ST_IDLE: begin
        // Without the go strobe nothing below runs and flags hold; output changes only by an output register write
        if (go) begin
          n.st = ldb_pkg::ST_RUN;
        end
      end
      ldb_pkg::ST_RUN: begin
        n.st = ldb_pkg::ST_IDLE;
        n.done = 1'b1;
        unique case (r.op)
          ldb_pkg::OP_LIMIT: begin
            bad = lim_bad;
            if (in_s < lo_s) begin
              res = lo_s;
              c_lt = 1'b1;
            end else if (in_s > hi_s) begin
              res = hi_s;
              c_gt = 1'b1;
            end else begin
              res = in_s;
            end
          end
          ldb_pkg::OP_BAND: begin
            bad = lim_bad;
            if (in_s < lo_s) begin
              res = in_s - lo_s;
              c_lt = 1'b1;
            end else if (in_s > hi_s) begin
              res = in_s - hi_s;
              c_gt = 1'b1;
            end else begin
              res = 16'sh0000;
              c_eq = 1'b1;
            end
          end
          ldb_pkg::OP_BIAS: begin
            bad = lim_bad;
            if (in_s < 16'sh0000) begin
              res = in_s + lo_s;
              c_lt = 1'b1;
            end else if (in_s > 16'sh0000) begin
              res = in_s + hi_s;
              c_gt = 1'b1;
            end else begin
              res = 16'sh0000;
              c_eq = 1'b1;
            end
          end
          ldb_pkg::OP_CTRL: begin
            bad = lim_bad | ~(&pband_dig_ok) | (r.pband == 16'h0000)
                  | ~(&period_dig_ok) | (r.period == 16'h0000)
                  | ~(&ival_dig_ok);
            // Forward acts on process minus target, reverse on the opposite
            dev = r.dir_fwd ? in_s - $signed(r.target)
                            : $signed(r.target) - in_s;
            if (dev > hi_s) begin
              res = hi_s;
              c_gt = 1'b1;
            end else if (dev < lo_s) begin
              res = lo_s;
              c_lt = 1'b1;
            end else begin
              res = dev;
            end
          end
        endcase
        bad = bad | ptr_fault;
        if (bad) begin
          // A rejected run keeps the output word and reports only the fault
          n.fault = 1'b1;
          n.carry = 1'b0;
          n.gt = 1'b0;
          n.eq = 1'b0;
          n.lt = 1'b0;
          n.neg = 1'b0;
        end else begin
          n.out_w = res;
          n.gt = c_gt;
          n.lt = c_lt;
          n.eq = c_eq | (res == 16'sh0000);
          n.neg = res[15];
          n.carry = r.op == ldb_pkg::OP_CTRL;
          // Late sampling still runs the step but is reported as a fault
          n.fault = (r.op == ldb_pkg::OP_CTRL)
                    && (ival_bin >= 16'(period_bin * 16'h0002));
        end
      end
      default: n.st = ldb_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= ldb_pkg::ST_IDLE;
      r.op <= ldb_pkg::OP_LIMIT;
      r.pband <= `RST_PBAND;
      r.period <= `RST_PERIOD;
      r.out_w <= `RST_WORD;
    end else begin
      r <= n;
    end
  end

  assign wb_dat_o = r.rdat;
  assign wb_ack_o = r.ack;
  assign result_o = r.out_w;
  assign fault_flag_o = r.fault;
  assign carry_flag_o = r.carry;
  assign greater_flag_o = r.gt;
  assign zero_result_flag_o = r.eq;
  assign less_flag_o = r.lt;
  assign negative_flag_o = r.neg;
  assign done_o = r.done;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic run;
  logic ok_run;
  logic ctrl_bad;
  assign run = r.st == ldb_pkg::ST_RUN;
  assign ok_run = run & ~lim_bad & ~ptr_fault & (r.op != ldb_pkg::OP_CTRL);
  // Worked out apart from the fault flag, so a carry on a rejected step is caught
  assign ctrl_bad = ~(&pband_dig_ok) | (r.pband == 16'h0000) | ~(&period_dig_ok)
                    | (r.period == 16'h0000) | ~(&ival_dig_ok);

  sequence s_go;
    go;
  endsequence

  sequence s_run_done;
    run ##1 (r.done && !run);
  endsequence

  a_exec_one_step: assert property (s_go |=> s_run_done)
    else $error("execution did not finish in one step");
  a_idle_holds: assert property ((!run && !out_wr) |=> $stable(r.out_w)
      && $stable({r.fault, r.carry, r.gt, r.eq, r.lt, r.neg}))
    else $error("output or flags changed without execution");
  a_clamp_low: assert property ((ok_run && r.op == ldb_pkg::OP_LIMIT && in_s < lo_s)
      |=> (r.out_w == $past(r.p0)) && r.lt && !r.gt)
    else $error("clamp below lower limit wrong");
  a_clamp_high: assert property ((ok_run && r.op == ldb_pkg::OP_LIMIT && in_s > hi_s)
      |=> (r.out_w == $past(r.p1)) && r.gt && !r.lt)
    else $error("clamp above upper limit wrong");
  a_clamp_pass: assert property ((ok_run && r.op == ldb_pkg::OP_LIMIT && in_s >= lo_s
      && in_s <= hi_s) |=> (r.out_w == $past(r.in_w)) && !r.gt && !r.lt)
    else $error("clamp pass-through wrong");
  a_band_low: assert property ((ok_run && r.op == ldb_pkg::OP_BAND && in_s < lo_s)
      |=> (r.out_w == 16'($past(r.in_w) - $past(r.p0))) && r.lt)
    else $error("band below lower limit wrong");
  a_band_mid: assert property ((ok_run && r.op == ldb_pkg::OP_BAND && in_s >= lo_s
      && in_s <= hi_s) |=> (r.out_w == 16'h0000) && r.eq && !r.gt && !r.lt)
    else $error("band inside window wrong");
  a_bias_neg: assert property ((ok_run && r.op == ldb_pkg::OP_BIAS && r.in_w[15])
      |=> (r.out_w == 16'($past(r.in_w) + $past(r.p0))) && r.lt)
    else $error("negative bias add wrong");
  a_fault_order: assert property ((run && lim_bad) |=> r.fault
      && (r.out_w == $past(r.out_w)))
    else $error("limit order fault missing");
  a_zero_flag: assert property ((r.done && !r.fault) |-> (r.eq == (r.out_w == 16'h0000)
      || (r.eq && $past(r.op) != ldb_pkg::OP_LIMIT)))
    else $error("equals flag disagrees with output");
  a_neg_flag: assert property ((r.done && !r.fault && $past(r.op) != ldb_pkg::OP_CTRL)
      |-> r.neg == r.out_w[15])
    else $error("negative flag disagrees with output");
  a_carry_exec: assert property (run |=> r.carry == ($past(r.op) == ldb_pkg::OP_CTRL
      && !$past(lim_bad | ptr_fault | ctrl_bad)))
    else $error("carry flag wrong after execution");
  a_one_cmp: assert property (r.done |-> $onehot0({r.gt, r.lt}) && !(r.eq && r.gt)
      && !(r.eq && r.lt))
    else $error("more than one comparison flag set");

endmodule

//--- verification/seq_model.sv
// Purpose: Instruction sequencer model that issues register requests
// Assumes: Classic Wishbone slave on the far side, one clock
// Notes: Released address and data are inverted so stale values stand out
`timescale 1ns/100ps

module seq_model (
  input wire logic clk_i,
  input wire logic wb_ack_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  // ----------------------------------------
  // Bus cycle
  // ----------------------------------------
  initial begin
    wb_cyc_o = 1'b0;
    wb_stb_o = 1'b0;
    wb_we_o = 1'b0;
    wb_adr_o = 8'h00;
    wb_sel_o = 4'h0;
    wb_dat_o = 32'h0000_0000;
  end

  task automatic xfer(input logic we, input logic [7:0] ad, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_o <= 1'b1;
    wb_stb_o <= 1'b1;
    wb_we_o <= we;
    wb_adr_o <= ad;
    wb_sel_o <= 4'hF;
    wb_dat_o <= d;
    // Next request waits for this answer, so go never overtakes operands
    @(posedge clk_i);
    while (wb_ack_i !== 1'b1) @(posedge clk_i);
    q = wb_dat_i;
    wb_cyc_o <= 1'b0;
    wb_stb_o <= 1'b0;
    wb_we_o <= 1'b0;
    wb_adr_o <= ~ad;
    wb_sel_o <= 4'h0;
    wb_dat_o <= ~d;
  endtask
endmodule

//--- verification/tb_limit_deadband_bias_unit.sv
// Purpose: Self-checking bench of the limit, dead-band and bias unit
// Assumes: seq_model drives the register bus, one request at a time
// Notes: Expected word and flags come from the model function, overridden by the fault kind
`timescale 1ns/100ps
`include "ldb_unit_regs.svh"
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module tb_limit_deadband_bias_unit;
  logic clk, rst, cyc, stb, we, ack, flt, cry, gt, eq, lt, neg, done;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dwr, drd, want;
  logic [15:0] res, x, a, b, t;
  logic signed [15:0] tgt;
  logic ptr_chk;
  logic [21:0] got, last_e;
  int n_errors = 0;
  int compares = 0;
  logic [49:0] corner [9] = '{
    {2'h0, 16'h8000, 16'h8000, 16'h7FFF}, {2'h0, 16'h7FFF, 16'h0000, 16'h7FFE},
    {2'h0, 16'h0000, 16'hFFF0, 16'h0010}, {2'h1, 16'h8000, 16'h0100, 16'h0200},
    {2'h1, 16'h0005, 16'h0005, 16'h0005}, {2'h1, 16'h7FFF, 16'h8000, 16'hFFFF},
    {2'h2, 16'h8000, 16'hFF00, 16'h0100}, {2'h2, 16'h0000, 16'hFF00, 16'h0100},
    {2'h2, 16'h7FFF, 16'hFF00, 16'h0001}};

  assign got = {res, flt, cry, gt, eq, lt, neg};

  limit_deadband_bias_unit dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd),
    .wb_ack_o(ack), .result_o(res), .fault_flag_o(flt), .carry_flag_o(cry),
    .greater_flag_o(gt), .zero_result_flag_o(eq), .less_flag_o(lt),
    .negative_flag_o(neg), .done_o(done));

  seq_model seq (.clk_i(clk), .wb_ack_i(ack), .wb_dat_i(drd), .wb_cyc_o(cyc), .wb_stb_o(stb),
    .wb_we_o(we), .wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dwr));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [21:0] model(input ldb_pkg::op_e op, input logic fwd,
                                        input logic signed [15:0] x, a, b);
    logic signed [15:0] r;
    logic g;
    logic l;
    r = x;
    if (op == ldb_pkg::OP_CTRL) r = fwd ? x - tgt : tgt - x;
    l = (op == ldb_pkg::OP_BIAS) ? (r < 16'sh0000) : (r < a);
    g = (op == ldb_pkg::OP_BIAS) ? (r > 16'sh0000) : (r > b);
    case (op)
      ldb_pkg::OP_BAND: r = l ? r - a : (g ? r - b : 16'sh0000);
      ldb_pkg::OP_BIAS: r = l ? r + a : (g ? r + b : 16'sh0000);
      default: r = l ? a : (g ? b : r);
    endcase
    return {r, 1'b0, op == ldb_pkg::OP_CTRL, g, r == 16'sh0000, l, r[15]};
  endfunction

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    logic [31:0] q;
    seq.xfer(1'b1, ad, {16'h0000, d}, q);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] q);
    seq.xfer(1'b0, ad, 32'h0000_0000, q);
  endtask

  // Fault kind: 0 none, 1 fault beside a normal run, 2 fault with output kept
  task automatic run(input ldb_pkg::op_e op, input logic fwd, input logic [15:0] x, a, b,
                     input logic [1:0] fk);
    logic [21:0] e;
    wr(`OFS_INPUT, x);
    wr(`OFS_PARAM0, a);
    wr(`OFS_PARAM1, b);
    wr(`OFS_CONTROL, 16'(op) | (16'(fwd) << `CTL_DIR_BIT) | (16'(ptr_chk) << `CTL_PTR_BCD_BIT));
    `CHK(got, last_e)
    wr(`OFS_COMMAND, 16'h0001);
    #1;
    `CHK(done, 1'b1)
    e = model(op, fwd, x, a, b);
    if (fk == 2'h2) e = {last_e[21:6], 6'h20};
    if (fk == 2'h1) e[5] = 1'b1;
    `CHK(got, e)
    last_e = e;
  endtask

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    print_verdict();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    rst = 1'b1;
    tgt = 16'sh0000;
    ptr_chk = 1'b0;
    last_e = 22'h000000;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(44));
    rd(`OFS_PBAND, q);
    `CHK(q, 32'h0000_0001)
    rd(`OFS_PERIOD, q);
    `CHK(q, 32'h0000_0001)
    wr(8'h40, 16'hBEEF);
    rd(8'h40, q);
    `CHK(q, 32'h0000_0000)
    `CHK(got, 22'h000000)
    $display("test reset done");
    foreach (corner[i]) begin
      run(ldb_pkg::op_e'(corner[i][49:48]), 1'b0, corner[i][47:32], corner[i][31:16],
          corner[i][15:0], 2'h0);
    end
    $display("test corners done");
    for (int i = 0; i < 40; i++) begin
      x = 16'($urandom);
      a = 16'($urandom);
      b = 16'($urandom);
      if ($signed(a) > $signed(b)) begin
        t = a;
        a = b;
        b = t;
      end
      run(ldb_pkg::op_e'($urandom_range(2, 0)), 1'b0, x, a, b, 2'h0);
    end
    $display("test random done");
    for (int i = 0; i < 3; i++) begin
      run(ldb_pkg::op_e'(i), 1'b0, 16'h0015, 16'h0020, 16'h0010, 2'h2);
    end
    ptr_chk = 1'b1;
    wr(`OFS_POINTER, 16'h00A5);
    run(ldb_pkg::OP_BAND, 1'b0, 16'h0030, 16'h0000, 16'h0010, 2'h2);
    wr(`OFS_POINTER, 16'h0099);
    run(ldb_pkg::OP_BAND, 1'b0, 16'h0030, 16'h0000, 16'h0010, 2'h0);
    ptr_chk = 1'b0;
    $display("test faults done");
    tgt = 16'sh0100;
    wr(`OFS_TARGET, 16'h0100);
    wr(`OFS_PERIOD, 16'h0010);
    wr(`OFS_INTERVAL, 16'h0019);
    for (int i = 0; i < 4; i++) begin
      run(ldb_pkg::OP_CTRL, i[0], i[1] ? 16'h7000 : 16'h0150, 16'hFF00, 16'h0100,
          2'h0);
    end
    wr(`OFS_INTERVAL, 16'h0020);
    run(ldb_pkg::OP_CTRL, 1'b1, 16'h0150, 16'hFF00, 16'h0100, 2'h1);
    wr(`OFS_PBAND, 16'h0000);
    run(ldb_pkg::OP_CTRL, 1'b1, 16'h0150, 16'hFF00, 16'h0100, 2'h2);
    $display("test control done");
    // Manual control: with no execution the output word belongs to software
    wr(`OFS_OUTPUT, 16'h1234);
    want = {10'h000, 16'h1234, last_e[5:0]};
    `CHK(got, want[21:0])
    rd(`OFS_OUTPUT, q);
    `CHK(q, 32'h0000_1234)
    // Flag register holds fault in bit 0 up to negative in bit 5
    want = {26'h0000000, last_e[0], last_e[1], last_e[2], last_e[3], last_e[4], last_e[5]};
    rd(`OFS_FLAGS, q);
    `CHK(q, want)
    rd(`OFS_CONTROL, q);
    `CHK(q, 32'h0000_0007)
    $display("test manual done");
    print_verdict();
  end
endmodule
